/* design/serial_fram_i2c_slave.sv */
// Two-wire serial slave front end of a 512-byte memory, with the array held here.
// Assumes bus pins arrive asynchronously and are oversampled by i_sys_clk; pins are open-drain outside.
// What this block does
// - SDA rising while SCL high is STOP; master drives it.
// - STOP abandons any transaction in progress at once.
// - SDA falling while SCL high is START; precedes each command.
// - START anywhere aborts and waits for a new slave address byte.
// - Data stable while SCL high; bits sampled in the high phase.
// - After eight bits transmitter releases SDA; receiver pulls low to acknowledge.
// - SDA high in acknowledge slot ends the transaction.
// - First byte after START is the address; top nibble must match type code.
// - Address bits 3-2 must equal the device select pins.
// - Address bit 1 picks the 256-byte half, the ninth address bit.
// - Address bit 0 one means read, zero means write.
// - Write sends a word-address byte; combined with page bit and latched.
// - Read uses latched low byte with page bit, no word address.
// - Address latch increments before each data acknowledge, wrapping to zero.
// - Read drives eight bits then samples ack; ack continues, nack ends.
// - Write receives eight bits then drives an acknowledge.
// - All bytes are shifted most significant bit first.
// - Array written on eighth data bit; START or STOP before leaves it alone.
// - Write protect high: no data acknowledge, address held.
// - No busy state; address after a write always acknowledged.
// - Random read: write address, word address, repeated START, read.
// - Sample on SCL rise, change output after SCL fall.
`default_nettype none
module serial_fram_i2c_slave
	import fram_i2c_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input  wire logic       i_sys_clk,            // 200 MHz system clock
	input  wire logic       i_sys_rst,            // Async reset, high
	input  wire logic       i_scl,                // Bus clock pin
	input  wire logic       i_sda,                // Bus data pin, level seen
	output logic            o_sda,                // Data pin drive value, always low
	output logic            o_sda_oe,             // High while pulling data low
	input  wire logic [1:0] i_device_select_pins, // Device select straps
	input  wire logic       i_write_protect,      // High blocks all writes
	output logic            o_selected,           // Device addressed in this transaction
	output logic [8:0]      o_addr_latch          // Current address latch
);
	import fram_i2c_pkg::*;

	logic [SYNC_STAGES-1:0] scl_sync;
	logic [SYNC_STAGES-1:0] sda_sync;
	logic [1:0]             sel_sync0;
	logic [1:0]             sel_sync1;
	logic                   wp_sync0;
	logic                   wp_sync1;
	logic                   scl_d;
	logic                   sda_d;
	logic                   scl_s;
	logic                   sda_s;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_det;
	logic                   stop_det;

	assign scl_s     = scl_sync[SYNC_STAGES-1];
	assign sda_s     = sda_sync[SYNC_STAGES-1];
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

	// Pin synchronisers; only the last stage is read by logic
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			scl_sync  <= '1;
			sda_sync  <= '1;
			sel_sync0 <= 2'h0;
			sel_sync1 <= 2'h0;
			wp_sync0  <= 1'b0;
			wp_sync1  <= 1'b0;
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
		end else begin
			scl_sync  <= {scl_sync[SYNC_STAGES-2:0], i_scl};
			sda_sync  <= {sda_sync[SYNC_STAGES-2:0], i_sda};
			sel_sync0 <= i_device_select_pins;
			sel_sync1 <= sel_sync0;
			wp_sync0  <= i_write_protect;
			wp_sync1  <= wp_sync0;
			scl_d     <= scl_s;
			sda_d     <= sda_s;
		end
	end

	slave_state_t      state;
	slave_state_t      next_state;
	logic [3:0]        bit_cnt;
	logic [3:0]        next_bit_cnt;
	logic [7:0]        shift;
	logic [7:0]        next_shift;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic              drive_low;
	logic              next_drive_low;
	logic              ack_pend;
	logic              next_ack_pend;
	logic              selected;
	logic              next_selected;
	logic              wr_valid;
	logic              wr_ready;
	mem_write_t        wr_cmd;
	mem_write_t        next_wr_cmd;
	logic              next_wr_valid;
	mem_write_t        mem_head;
	logic              mem_valid;
	logic [WORD_W-1:0] mem [MEM_DEPTH];
	logic [WORD_W-1:0] rd_byte;
	logic              in_ack;
	logic              addr_match;

	assign in_ack     = (bit_cnt == ACK_BIT);
	// Judged on the eighth rise, before the last bit lands: shift still holds the byte one place lower
	assign addr_match = (shift[TYPE_HI-1:TYPE_LO-1] == TYPE_CODE) && (shift[SEL_HI-1:SEL_LO-1] == sel_sync1);
	// Array is read where the pointer stands; writes drain ahead of the next byte
	assign rd_byte    = mem[addr];

	always_comb begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_shift     = shift;
		next_addr      = addr;
		next_drive_low = drive_low;
		next_ack_pend  = ack_pend;
		next_selected  = selected;
		next_wr_cmd    = wr_cmd;
		next_wr_valid  = wr_valid && !wr_ready;
		if (start_det) begin
			next_state     = ST_DEV_ADDR;
			next_bit_cnt   = 4'h0;
			next_drive_low = 1'b0;
			next_ack_pend  = 1'b0;
			next_selected  = 1'b0;
		end else if (stop_det) begin
			next_state     = ST_IDLE;
			next_drive_low = 1'b0;
			next_ack_pend  = 1'b0;
			next_selected  = 1'b0;
		end else if (scl_rise && state != ST_IDLE && state != ST_IGNORE) begin
			if (in_ack) begin
				// Acknowledge slot sample
				next_bit_cnt = 4'h0;
				if (state == ST_READ) begin
					if (sda_s) begin
						next_state = ST_IGNORE;
					end else begin
						next_shift = rd_byte;
					end
				end else if (!ack_pend) begin
					next_state = ST_IGNORE;
				end
			end else begin
				next_shift   = {shift[6:0], sda_s};
				next_bit_cnt = bit_cnt + 4'h1;
				if (state == ST_READ) begin
					next_shift = {shift[6:0], 1'b0};
				end
				if (bit_cnt == LAST_BIT) begin
					unique case (state)
						ST_DEV_ADDR: begin
							next_ack_pend = addr_match;
							next_selected = addr_match;
							if (addr_match) begin
								next_addr[ADDR_W-1] = next_shift[PAGE_BIT];
								if (next_shift[DIR_BIT]) begin
									next_state = ST_READ;
								end else begin
									next_state = ST_WORD_ADDR;
								end
							end else begin
								next_state = ST_IGNORE;
							end
						end
						ST_WORD_ADDR: begin
							next_addr[WORD_W-1:0] = next_shift;
							next_ack_pend         = 1'b1;
							next_state            = ST_WRITE;
						end
						ST_WRITE: begin
							next_ack_pend = !wp_sync1 && wr_ready;
							if (!wp_sync1 && wr_ready) begin
								next_wr_cmd.addr = addr;
								next_wr_cmd.data = next_shift;
								next_wr_valid    = 1'b1;
								next_addr        = addr + 9'h001;
							end
						end
						ST_READ: begin
							next_ack_pend = 1'b0;
							next_addr     = addr + 9'h001;
						end
						default: begin
							next_ack_pend = 1'b0;
						end
					endcase
				end
			end
		end else if (scl_fall) begin
			// Output moves only after the clock falls
			next_drive_low = 1'b0;
			// The read address byte is acknowledged too; ack_pend is clear on read data slots
			if (in_ack && state != ST_IGNORE && state != ST_IDLE) begin
				next_drive_low = ack_pend;
			end else if (state == ST_READ && !in_ack) begin
				next_drive_low = !shift[7];
			end
		end
		// Current-address read: load the first byte once the page bit is known
		if (state == ST_DEV_ADDR && next_state == ST_READ) begin
			next_shift = mem[next_addr];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state     <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= WORD_RST;
			addr      <= ADDR_RST;
			drive_low <= 1'b0;
			ack_pend  <= 1'b0;
			selected  <= 1'b0;
			wr_cmd    <= '0;
			wr_valid  <= 1'b0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			addr      <= next_addr;
			drive_low <= next_drive_low;
			ack_pend  <= next_ack_pend;
			selected  <= next_selected;
			wr_cmd    <= next_wr_cmd;
			wr_valid  <= next_wr_valid;
		end
	end

	// Buffer decouples byte capture from the array port; a full buffer refuses the byte
	two_entry_buffer #(
		.WIDTH ($bits(mem_write_t))
	) u_wr_buf (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_data    (wr_cmd),
		.i_valid   (wr_valid),
		.o_ready   (wr_ready),
		.o_data    (mem_head),
		.o_valid   (mem_valid),
		.i_ready   (1'b1)
	);

	always_ff @(posedge i_sys_clk) begin
		if (mem_valid) begin
			mem[mem_head.addr] <= mem_head.data;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sda        <= 1'b0;
			o_sda_oe     <= 1'b0;
			o_selected   <= 1'b0;
			o_addr_latch <= ADDR_RST;
		end else begin
			o_sda        <= 1'b0;
			o_sda_oe     <= next_drive_low;
			o_selected   <= next_selected;
			o_addr_latch <= next_addr;
		end
	end
endmodule : serial_fram_i2c_slave
`default_nettype wire

/* design/fram_i2c_pkg.sv */
// Package for the two-wire memory slave: address byte layout, sizes, states and carrier types.
// Assumes a single system clock that oversamples the bus pins.
`default_nettype none
package fram_i2c_pkg;
	localparam int          ADDR_W       = 9;
	localparam int          WORD_W       = 8;
	localparam int          MEM_DEPTH    = 512;
	localparam logic [3:0]  TYPE_CODE    = 4'h5;      // Arbitrary device-type code, not a real part's
	localparam int          TYPE_HI      = 7;
	localparam int          TYPE_LO      = 4;
	localparam int          SEL_HI       = 3;
	localparam int          SEL_LO       = 2;
	localparam int          PAGE_BIT     = 1;
	localparam int          DIR_BIT      = 0;
	localparam logic [3:0]  LAST_BIT     = 4'h7;
	localparam logic [3:0]  ACK_BIT      = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
	localparam logic [WORD_W-1:0] WORD_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV_ADDR,
		ST_WORD_ADDR,
		ST_WRITE,
		ST_READ,
		ST_IGNORE
	} slave_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} mem_write_t;
endpackage : fram_i2c_pkg
`default_nettype wire

/* design/two_entry_buffer.sv */
// Two-entry valid/ready buffer for memory write commands.
// Assumes both sides on the same clock; reset asynchronous, active high.
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 17
) (
	input  wire logic             i_sys_clk,  // System clock
	input  wire logic             i_sys_rst,  // Async reset, high
	input  wire logic [WIDTH-1:0] i_data,     // Fill data
	input  wire logic             i_valid,    // Fill valid
	output logic                  o_ready,    // Room for one more
	output logic [WIDTH-1:0]      o_data,     // Head data
	output logic                  o_valid,    // Head valid
	input  wire logic             i_ready     // Drain accepts
);
	logic [WIDTH-1:0] slot [2];
	logic [1:0]       count;
	logic             rd_ptr;
	logic             wr_ptr;
	logic [1:0]       next_count;
	logic             next_rd_ptr;
	logic             next_wr_ptr;
	logic             push;
	logic             pop;

	assign o_ready = (count != 2'h2);
	assign o_valid = (count != 2'h0);
	assign o_data  = slot[rd_ptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb begin
		next_count  = count;
		next_rd_ptr = rd_ptr;
		next_wr_ptr = wr_ptr;
		if (push) begin
			next_wr_ptr = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		if (push && !pop) begin
			next_count = count + 2'h1;
		end else if (pop && !push) begin
			next_count = count - 2'h1;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count  <= 2'h0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end else begin
			count  <= next_count;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
		end
	end

	// Storage carries no reset so it maps to plain registers
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			slot[wr_ptr] <= i_data;
		end
	end
endmodule : two_entry_buffer
`default_nettype wire

/* bench/fram_slave_properties.sv */
// Assertions on the memory slave's bus pins and status outputs.
// Bound to the slave from the testbench; sees only the slave's ports.
`default_nettype none
module fram_slave_properties (
	input wire logic       i_sys_clk,            // System clock
	input wire logic       i_sys_rst,            // Async reset, high
	input wire logic       i_scl,                // Bus clock pin
	input wire logic       i_sda,                // Resolved data line
	input wire logic       o_sda,                // Drive value
	input wire logic       o_sda_oe,             // Pull-down enable
	input wire logic [1:0] i_device_select_pins, // Select straps
	input wire logic       i_write_protect,      // Write protect
	input wire logic       o_selected,           // Addressed flag
	input wire logic [8:0] o_addr_latch          // Address pointer
);
	logic scl_q;
	logic sda_q;
	logic start_seen;
	logic stop_seen;
	// Idle bus is high on both lines, so reset to that to avoid a false condition
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end
	assign start_seen = scl_q & i_scl & sda_q & ~i_sda;
	assign stop_seen  = scl_q & i_scl & ~sda_q & i_sda;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	property p_reset_state; $fell(i_sys_rst) |-> !o_sda_oe && !o_selected && o_addr_latch == 9'h000; endproperty
	a_reset_state: assert property (p_reset_state) else $error("outputs not at reset values");
	property p_drive_low; o_sda_oe |-> o_sda == 1'b0; endproperty
	a_drive_low: assert property (p_drive_low) else $error("data line driven high");
	property p_drive_on_low; $rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 3); endproperty
	a_drive_on_low: assert property (p_drive_on_low) else $error("data drive began outside clock low");
	property p_stable_high; i_scl [*8] |-> $stable(o_sda_oe); endproperty
	a_stable_high: assert property (p_stable_high) else $error("data drive moved while clock high");
	property p_start_drop; start_seen |-> ##[1:8] !o_selected; endproperty
	a_start_drop: assert property (p_start_drop) else $error("start did not end the transaction");
	property p_stop_drop; stop_seen |-> ##[1:8] !o_selected && !o_sda_oe; endproperty
	a_stop_drop: assert property (p_stop_drop) else $error("stop did not end the transaction");
	property p_count_high; o_addr_latch == $past(o_addr_latch) + 9'h001 |-> i_scl; endproperty
	a_count_high: assert property (p_count_high) else $error("address stepped while clock low");
	property p_oe_selected; o_sda_oe && !o_selected |-> $past(o_selected); endproperty
	a_oe_selected: assert property (p_oe_selected) else $error("unselected device drives data");
endmodule // fram_slave_properties
`default_nettype wire

/* bench/i2c_master_model.sv */
// Behavioural two-wire bus master: start, stop, byte write and byte read.
// Assumes an open-drain line resolved outside; a bus clock period of 32 system clocks.
`default_nettype none
module i2c_master_model (
	input  wire logic i_clk, // System clock
	input  wire logic i_sda, // Resolved data line
	output var  logic o_scl, // Bus clock
	output var  logic o_sda  // Data drive, one releases
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic wait_q();
		repeat (8) @(negedge i_clk);
	endtask
	// Data only moves while the clock is low; sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		wait_q();
		o_scl = 1'b1;
		wait_q();
		r = i_sda;
		wait_q();
		o_scl = 1'b0;
		wait_q();
	endtask
	task automatic send_start();
		o_sda = 1'b1;
		wait_q();
		o_scl = 1'b1;
		wait_q();
		o_sda = 1'b0;
		wait_q();
		o_scl = 1'b0;
		wait_q();
	endtask
	task automatic send_stop();
		o_sda = 1'b0;
		wait_q();
		o_scl = 1'b1;
		wait_q();
		o_sda = 1'b1;
		wait_q();
	endtask
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic read_byte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!ack, r);
	endtask
endmodule // i2c_master_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the two-wire memory slave.
// Assumes the design package and the master model are compiled first.
`default_nettype none
module testbench;
	import fram_i2c_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       wp = 1'b0;
	logic [1:0] pins = 2'h2;
	logic       scl, m_sda, oe, drv, sel, a;
	logic [8:0] latch;
	logic [7:0] d;
	logic [7:0] wr [3] = '{8'ha5, 8'h3c, 8'h0f};
	int         n_mismatch = 0, n_tests = 0, cycles = 0;
	wire        sda_bus;
	// Pull-up on the line: any pull-down wins
	assign sda_bus = m_sda & (oe ? drv : 1'b1);
	i2c_master_model i_master (.i_clk(clk), .i_sda(sda_bus), .o_scl(scl), .o_sda(m_sda));
	serial_fram_i2c_slave i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda_bus),
		.o_sda(drv), .o_sda_oe(oe), .i_device_select_pins(pins), .i_write_protect(wp),
		.o_selected(sel), .o_addr_latch(latch));
	always #2.5 clk = ~clk;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic dev(input logic [1:0] s, input logic pg, input logic rd, input logic [3:0] t = TYPE_CODE);
		i_master.send_start();
		i_master.write_byte({t, s, pg, rd}, a);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		dev(pins, 1'b1, 1'b0);
		check(a, 1);
		check(sel, 1);
		i_master.write_byte(8'hfe, a);
		check(latch, 9'h1fe);
		foreach (wr[i]) begin
			i_master.write_byte(wr[i], a);
			check(a, 1);
		end
		check(latch, 9'h001);
		i_master.send_stop();
		repeat (8) @(negedge clk);
		check(sel, 0);
		dev(pins, 1'b1, 1'b0);
		check(a, 1);
		i_master.write_byte(8'hfe, a);
		dev(pins, 1'b1, 1'b1);
		foreach (wr[i]) begin
			i_master.read_byte(d, i < 2);
			check(d, wr[i]);
		end
		i_master.send_stop();
		// Wrong select straps, then wrong type code: both must stay silent
		for (int k = 0; k < 2; k++) begin
			dev(k ? pins : ~pins, 1'b0, 1'b0, k ? ~TYPE_CODE : TYPE_CODE);
			check(a, 0);
			check(sel, 0);
			i_master.send_stop();
		end
		dev(pins, 1'b1, 1'b0);
		i_master.write_byte(8'hff, a);
		wp = 1'b1;
		i_master.write_byte(8'h77, a);
		check(a, 0);
		check(latch, 9'h1ff);
		wp = 1'b0;
		dev(pins, 1'b1, 1'b1);
		i_master.read_byte(d, 1'b0);
		check(d, 8'h3c);
		i_master.send_stop();
		// Stop after half a data byte leaves the array alone
		dev(pins, 1'b0, 1'b0);
		i_master.write_byte(8'h00, a);
		repeat (4) i_master.bit_io(1'b1, a);
		i_master.send_stop();
		dev(pins, 1'b0, 1'b1);
		i_master.read_byte(d, 1'b0);
		check(d, 8'h0f);
		i_master.send_stop();
		give_verdict();
	end
endmodule // testbench
bind serial_fram_i2c_slave fram_slave_properties i_props (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_device_select_pins(i_device_select_pins),
	.i_write_protect(i_write_protect), .o_selected(o_selected), .o_addr_latch(o_addr_latch));
`default_nettype wire
